// ==== src/wsmtx_pkg.sv ====
// Shared constants, types and code-generator functions of the tone encoder
package wsmtx_pkg;
	// Timing
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned SAMPLE_HZ = 11025;
	localparam int unsigned LEAD_S = 1;
	localparam logic [14:0] LEAD_SAMPLES = 15'(SAMPLE_HZ * LEAD_S);
	localparam logic [14:0] NORM_SAMPLES = 15'h1000;
	localparam logic [14:0] SHORT_SAMPLES = 15'h4000;
	localparam logic [6:0] NUM_INTERVALS = 7'h7E;
	// Code geometry
	localparam int NUM_DATA = 12;
	localparam int NUM_PAR = 51;
	localparam int ROWS = 7;
	localparam int COLS = 9;
	localparam int TONE_W = 9;
	localparam logic [5:0] GF_REDUCE = 6'h03;
	localparam logic [5:0] GF_ALPHA = 6'h02;
	localparam int GEN_FCR = 3;
	localparam logic [8:0] TONE_BASE_STEP = 9'h002;
	localparam logic [8:0] SHORT_STEP = 9'h00A;
	localparam logic [125:0] SYNC_DEFAULT = 126'h2AAAAAAAAAAAAAAAAAAAAAAAAAAAAAAA;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MSG0 = 8'h04;
	localparam logic [7:0] OFS_MSG1 = 8'h08;
	localparam logic [7:0] OFS_MSG2 = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// Control fields
	localparam int CTRL_ARM = 0;
	localparam int CTRL_REP = 1;
	localparam int CTRL_SHORT = 2;
	localparam int CTRL_NSEL = 3;
	localparam int CTRL_SUB = 5;
	localparam int CTRL_ODD = 7;
	localparam int CTRL_STOP = 8;
	// Status fields
	localparam int STS_IV = 0;
	localparam int STS_STATE = 8;
	localparam int STS_BUSY = 12;
	localparam int STS_MPAR = 13;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ENCODE, ST_ARMED, ST_LEAD, ST_NORMAL, ST_SHORT
	} wsmtx_state_type;

	typedef enum logic [2:0] {
		R_CTRL, R_MSG0, R_MSG1, R_MSG2, R_STATUS, R_NONE
	} wsmtx_reg_type;

	function automatic logic [5:0] gf_mul(logic [5:0] a, logic [5:0] b);
		logic [5:0] r;
		logic [5:0] x;
		r = '0;
		x = a;
		for (int i = 0; i < 6; i++) begin
			if (b[i]) begin
				r = r ^ x;
			end
			x = x[5] ? ({x[4:0], 1'b0} ^ GF_REDUCE) : {x[4:0], 1'b0};
		end
		return r;
	endfunction : gf_mul

	// Generator of the 51-parity code, leading coefficient in entry 51
	function automatic logic [51:0][5:0] gen_poly();
		logic [51:0][5:0] g;
		logic [5:0] root;
		g = '0;
		g[0] = 6'h01;
		root = 6'h01;
		for (int i = 0; i < GEN_FCR; i++) begin
			root = gf_mul(root, GF_ALPHA);
		end
		for (int i = 0; i < NUM_PAR; i++) begin
			for (int j = i + 1; j >= 1; j--) begin
				g[j] = g[j-1] ^ gf_mul(g[j], root);
			end
			g[0] = gf_mul(g[0], root);
			root = gf_mul(root, GF_ALPHA);
		end
		return g;
	endfunction : gen_poly

	localparam logic [51:0][5:0] GEN = gen_poly();
endpackage : wsmtx_pkg

// ==== src/wsmtx_stream_if.sv ====
// Valid/ready word stream between the sequencer and its output buffer
`timescale 1ns/10ps
`default_nettype none
interface wsmtx_stream_if #(parameter int W = 9) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : wsmtx_stream_if
`default_nettype wire

// ==== src/wsmtx_buf.sv ====
// Small shift-register FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module wsmtx_buf #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Streams
	wsmtx_stream_if.snk in_s,
	wsmtx_stream_if.src out_s
);
	typedef struct packed {
		logic [DEPTH-1:0] v;
		logic [DEPTH-1:0][WIDTH-1:0] d;
	} wsmtx_buf_state_type;

	wsmtx_buf_state_type s_q;
	wsmtx_buf_state_type s_d;
	logic placed;

	always_comb begin
		s_d = s_q;
		placed = 1'b0;
		if (s_q.v[0] && out_s.ready) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_d.v[i] = s_q.v[i+1];
				s_d.d[i] = s_q.d[i+1];
			end
			s_d.v[DEPTH-1] = 1'b0;
		end
		// Full is judged before the pop, so a word is never overwritten
		if (in_s.valid && !s_q.v[DEPTH-1]) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !s_d.v[i]) begin
					s_d.v[i] = 1'b1;
					s_d.d[i] = in_s.data;
					placed = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign in_s.ready = !s_q.v[DEPTH-1];
	assign out_s.valid = s_q.v[0];
	assign out_s.data = s_q.d[0];
endmodule : wsmtx_buf
`default_nettype wire

// ==== src/wsmtx_top.sv ====
// Weak-signal multi-tone transmit encoder and tone sequencer, AHB-Lite slave
// Behaviour
// - Payload is twelve 6-bit symbols, 72 bits
// - Code 12 symbols into 63 with 51 parity
// - Write 7x9 array by rows, read columns
// - Gray code each symbol before tone choice
// - Send 126 intervals of 4096 samples each
// - One steady tone per interval, phase continuous
// - Start one second after minute, end 47.8s
// - Pattern bit one selects the sync tone
// - Data symbols in order in non-sync intervals
// - Data tone step is (N+2) times multiplier
// - Multiplier 1, 2 or 4 by submode
// - Report flag swaps sync and data intervals
// - Alternate one-minute transmit and receive periods
// - Normal messages start only at minute boundary
// - Shorthand alternates two tones, 16384 samples each
// - Shorthand upper tone is 10*n*m steps up
// - Shorthand may start anytime in transmit minute
`timescale 1ns/10ps
`default_nettype none
module wsmtx_top #(
	parameter int unsigned CLK_HZ = wsmtx_pkg::CLK_HZ,
	parameter int unsigned SAMPLE_HZ = wsmtx_pkg::SAMPLE_HZ,
	parameter logic [14:0] LEAD_SAMPLES = wsmtx_pkg::LEAD_SAMPLES,
	parameter logic [14:0] NORM_SAMPLES = wsmtx_pkg::NORM_SAMPLES,
	parameter logic [14:0] SHORT_SAMPLES = wsmtx_pkg::SHORT_SAMPLES,
	parameter logic [125:0] SYNC_PATTERN = wsmtx_pkg::SYNC_DEFAULT
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Time reference
	input wire logic minute_tick,
	// Tone synthesizer
	output logic [8:0] tone_code,
	output logic tone_valid,
	input wire logic tone_ready,
	output logic tx_active
);
	typedef struct packed {
		wsmtx_pkg::wsmtx_state_type st;
		logic [26:0] acc;
		logic smp;
		logic [14:0] cnt;
		logic [6:0] iv;
		logic [5:0] dcnt;
		logic [3:0] enc;
		logic [2:0] r;
		logic [3:0] c;
		logic [11:0][5:0] msg;
		logic [50:0][5:0] par;
		logic rep;
		logic [1:0] nsel;
		logic [1:0] sub;
		logic odd;
		logic mpar;
		logic pend;
		logic [8:0] tone;
		logic hi;
		logic ap;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic rdy;
		logic act;
	} wsmtx_top_state_type;

	wsmtx_top_state_type s_q;
	wsmtx_top_state_type s_d;
	logic [27:0] sum;
	logic adv;
	logic ld;
	logic [6:0] liv;
	logic [5:0] fb;
	logic [5:0] src;
	logic [5:0] sym;
	logic [5:0] gray;
	int mk;

	wsmtx_stream_if #(.W(wsmtx_pkg::TONE_W)) buf_in ();
	wsmtx_stream_if #(.W(wsmtx_pkg::TONE_W)) buf_out ();

	function automatic wsmtx_pkg::wsmtx_reg_type reg_sel(logic [7:0] a);
		unique case (a)
			wsmtx_pkg::OFS_CTRL: return wsmtx_pkg::R_CTRL;
			wsmtx_pkg::OFS_MSG0: return wsmtx_pkg::R_MSG0;
			wsmtx_pkg::OFS_MSG1: return wsmtx_pkg::R_MSG1;
			wsmtx_pkg::OFS_MSG2: return wsmtx_pkg::R_MSG2;
			wsmtx_pkg::OFS_STATUS: return wsmtx_pkg::R_STATUS;
			default: return wsmtx_pkg::R_NONE;
		endcase
	endfunction : reg_sel

	always_comb begin
		s_d = s_q;
		ld = 1'b0;
		liv = '0;
		fb = '0;
		src = '0;
		sym = '0;
		gray = '0;
		mk = 0;
		// Fractional divider gives the 11025/s sample enable
		sum = 28'(s_q.acc) + 28'(SAMPLE_HZ);
		s_d.smp = 1'b0;
		s_d.acc = sum[26:0];
		if (sum >= 28'(CLK_HZ)) begin
			s_d.acc = 27'(sum - 28'(CLK_HZ));
			s_d.smp = 1'b1;
		end
		// Output buffer full stalls the interval count
		if (s_q.pend && buf_in.ready) begin
			s_d.pend = 1'b0;
		end
		adv = s_q.smp && !s_q.pend;
		if (minute_tick) begin
			s_d.mpar = ~s_q.mpar;
		end
		unique case (s_q.st)
			wsmtx_pkg::ST_IDLE: begin
			end
			wsmtx_pkg::ST_ENCODE: begin
				fb = s_q.msg[s_q.enc] ^ s_q.par[50];
				for (int j = 50; j >= 1; j--) begin
					s_d.par[j] = s_q.par[j-1] ^ wsmtx_pkg::gf_mul(fb, wsmtx_pkg::GEN[j]);
				end
				s_d.par[0] = wsmtx_pkg::gf_mul(fb, wsmtx_pkg::GEN[0]);
				s_d.enc = s_q.enc + 4'h1;
				if (s_q.enc == 4'(wsmtx_pkg::NUM_DATA - 1)) begin
					s_d.st = wsmtx_pkg::ST_ARMED;
				end
			end
			wsmtx_pkg::ST_ARMED: begin
				if (minute_tick && (~s_q.mpar == s_q.odd)) begin
					s_d.st = wsmtx_pkg::ST_LEAD;
					s_d.cnt = '0;
				end
			end
			wsmtx_pkg::ST_LEAD: begin
				if (adv) begin
					s_d.cnt = s_q.cnt + 15'h0001;
					if (s_q.cnt == LEAD_SAMPLES - 15'h0001) begin
						s_d.st = wsmtx_pkg::ST_NORMAL;
						s_d.cnt = '0;
						ld = 1'b1;
					end
				end
			end
			wsmtx_pkg::ST_NORMAL: begin
				if (adv) begin
					s_d.cnt = s_q.cnt + 15'h0001;
					if (s_q.cnt == NORM_SAMPLES - 15'h0001) begin
						s_d.cnt = '0;
						if (s_q.iv == wsmtx_pkg::NUM_INTERVALS - 7'h01) begin
							s_d.st = wsmtx_pkg::ST_IDLE;
						end else begin
							ld = 1'b1;
							liv = s_q.iv + 7'h01;
						end
					end
				end
			end
			wsmtx_pkg::ST_SHORT: begin
				// shorthand ends with the transmit minute
				if (minute_tick) begin
					s_d.st = wsmtx_pkg::ST_IDLE;
				end else if (adv) begin
					s_d.cnt = s_q.cnt + 15'h0001;
					if (s_q.cnt == SHORT_SAMPLES - 15'h0001) begin
						s_d.cnt = '0;
						s_d.hi = ~s_q.hi;
						s_d.pend = 1'b1;
						s_d.tone = '0;
						// upper tone ten steps per n
						if (!s_q.hi) begin
							s_d.tone = ((9'(s_q.nsel) + 9'h002) * wsmtx_pkg::SHORT_STEP)
								<< s_q.sub;
						end
					end
				end
			end
			default: begin
				s_d.st = wsmtx_pkg::ST_IDLE;
			end
		endcase
		// one tone word per interval start
		if (ld) begin
			s_d.iv = liv;
			s_d.pend = 1'b1;
			if (SYNC_PATTERN[liv] ^ s_q.rep) begin
				s_d.tone = '0;
			end else begin
				src = 6'(s_q.r) * 6'(wsmtx_pkg::COLS) + 6'(s_q.c);
				sym = (src < 6'(wsmtx_pkg::NUM_DATA)) ? s_q.msg[src[3:0]]
					: s_q.par[6'(62) - src];
				gray = sym ^ (sym >> 1);
				s_d.tone = (9'(gray) + wsmtx_pkg::TONE_BASE_STEP) << s_q.sub;
				s_d.dcnt = s_q.dcnt + 6'h01;
				s_d.r = s_q.r + 3'h1;
				if (s_q.r == 3'(wsmtx_pkg::ROWS - 1)) begin
					s_d.r = '0;
					s_d.c = s_q.c + 4'h1;
				end
			end
		end
		// Bus address phase; reads are answered with zero wait states
		s_d.rdy = 1'b1;
		s_d.ap = 1'b0;
		if (hsel && hready && htrans[1] && hsize == wsmtx_pkg::HSIZE_WORD) begin
			s_d.ap = hwrite;
			s_d.addr = haddr[7:0];
			s_d.rdata = '0;
			unique case (reg_sel(haddr[7:0]))
				wsmtx_pkg::R_CTRL: begin
					s_d.rdata[wsmtx_pkg::CTRL_REP] = s_q.rep;
					s_d.rdata[wsmtx_pkg::CTRL_NSEL +: 2] = s_q.nsel;
					s_d.rdata[wsmtx_pkg::CTRL_SUB +: 2] = s_q.sub;
					s_d.rdata[wsmtx_pkg::CTRL_ODD] = s_q.odd;
				end
				wsmtx_pkg::R_MSG0, wsmtx_pkg::R_MSG1, wsmtx_pkg::R_MSG2: begin
					mk = int'(reg_sel(haddr[7:0])) - int'(wsmtx_pkg::R_MSG0);
					for (int i = 0; i < 4; i++) begin
						s_d.rdata[6*i +: 6] = s_q.msg[4*mk + i];
					end
				end
				wsmtx_pkg::R_STATUS: begin
					s_d.rdata[wsmtx_pkg::STS_IV +: 7] = s_q.iv;
					s_d.rdata[wsmtx_pkg::STS_STATE +: 3] = s_q.st;
					s_d.rdata[wsmtx_pkg::STS_BUSY] = s_q.st != wsmtx_pkg::ST_IDLE;
					s_d.rdata[wsmtx_pkg::STS_MPAR] = s_q.mpar;
				end
				default: begin
				end
			endcase
		end
		// Bus write data phase
		if (s_q.ap) begin
			unique case (reg_sel(s_q.addr))
				wsmtx_pkg::R_CTRL: begin
					if (s_q.st == wsmtx_pkg::ST_IDLE) begin
						s_d.rep = hwdata[wsmtx_pkg::CTRL_REP];
						s_d.nsel = (hwdata[wsmtx_pkg::CTRL_NSEL +: 2] == 2'h3) ? 2'h2
							: hwdata[wsmtx_pkg::CTRL_NSEL +: 2];
						s_d.sub = (hwdata[wsmtx_pkg::CTRL_SUB +: 2] == 2'h3) ? 2'h2
							: hwdata[wsmtx_pkg::CTRL_SUB +: 2];
						s_d.odd = hwdata[wsmtx_pkg::CTRL_ODD];
						if (hwdata[wsmtx_pkg::CTRL_ARM]) begin
							s_d.st = wsmtx_pkg::ST_ENCODE;
							s_d.enc = '0;
							s_d.par = '0;
							s_d.r = '0;
							s_d.c = '0;
							s_d.dcnt = '0;
							s_d.iv = '0;
						// shorthand starts at once in transmit minute
						end else if (hwdata[wsmtx_pkg::CTRL_SHORT] &&
							s_q.mpar == hwdata[wsmtx_pkg::CTRL_ODD]) begin
							s_d.st = wsmtx_pkg::ST_SHORT;
							s_d.cnt = '0;
							s_d.hi = 1'b0;
							s_d.tone = '0;
							s_d.pend = 1'b1;
						end
					end
					if (hwdata[wsmtx_pkg::CTRL_STOP]) begin
						s_d.st = wsmtx_pkg::ST_IDLE;
					end
				end
				wsmtx_pkg::R_MSG0, wsmtx_pkg::R_MSG1, wsmtx_pkg::R_MSG2: begin
					// twelve 6-bit symbols, four per word
					mk = int'(reg_sel(s_q.addr)) - int'(wsmtx_pkg::R_MSG0);
					if (s_q.st == wsmtx_pkg::ST_IDLE) begin
						for (int i = 0; i < 4; i++) begin
							s_d.msg[4*mk + i] = hwdata[6*i +: 6];
						end
					end
				end
				default: begin
				end
			endcase
		end
		s_d.act = s_d.st inside {wsmtx_pkg::ST_LEAD, wsmtx_pkg::ST_NORMAL,
			wsmtx_pkg::ST_SHORT};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign buf_in.valid = s_q.pend;
	assign buf_in.data = s_q.tone;
	assign buf_out.ready = tone_ready;

	wsmtx_buf #(
		.WIDTH(wsmtx_pkg::TONE_W),
		.DEPTH(2)
	) u_buf (
		.clk(hclk),
		.rst_n(hresetn),
		.in_s(buf_in),
		.out_s(buf_out)
	);

	assign hreadyout = s_q.rdy;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	// code is the buffer head word, held only until the synthesizer takes it
	assign tone_code = buf_out.data;
	assign tone_valid = buf_out.valid;
	assign tx_active = s_q.act;

	a_encode_len:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s_q.st == wsmtx_pkg::ST_ENCODE) && $past(s_q.st) == wsmtx_pkg::ST_IDLE
		|-> (s_q.st == wsmtx_pkg::ST_ENCODE)[*8] ##5 s_q.st == wsmtx_pkg::ST_ARMED)
		else $error("encode phase length wrong");

	a_lead_tick:
	assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.st == wsmtx_pkg::ST_LEAD && $past(s_q.st) == wsmtx_pkg::ST_ARMED
		|-> $past(minute_tick))
		else $error("normal message started off the minute");

	a_tx_minute:
	assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.st == wsmtx_pkg::ST_LEAD |-> s_q.mpar == s_q.odd)
		else $error("lead-in outside transmit minute");

	a_data_count:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$past(s_q.st) == wsmtx_pkg::ST_NORMAL && s_q.st == wsmtx_pkg::ST_IDLE
		&& !$past(s_q.ap) |-> s_q.dcnt == 6'h3F)
		else $error("data symbol count not 63 at end");

	a_interval_wrap:
	assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.st == wsmtx_pkg::ST_NORMAL && adv && s_q.cnt == NORM_SAMPLES - 15'h0001
		&& s_q.iv != wsmtx_pkg::NUM_INTERVALS - 7'h01 && !s_q.ap
		|=> s_q.cnt == 15'h0000 && s_q.iv == $past(s_q.iv) + 7'h01 && s_q.pend)
		else $error("interval did not advance");

	a_sync_tone:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s_q.pend) && s_q.st == wsmtx_pkg::ST_NORMAL
		&& (SYNC_PATTERN[s_q.iv] ^ s_q.rep) |-> s_q.tone == 9'h000)
		else $error("sync interval not at sync tone");

	a_data_tone:
	assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s_q.pend) && s_q.st == wsmtx_pkg::ST_NORMAL
		&& !(SYNC_PATTERN[s_q.iv] ^ s_q.rep)
		|-> s_q.tone >= (wsmtx_pkg::TONE_BASE_STEP << s_q.sub))
		else $error("data tone below base step");

	a_short_hold:
	assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.st == wsmtx_pkg::ST_SHORT && $past(s_q.st) == wsmtx_pkg::ST_SHORT
		&& $past(s_q.cnt) != SHORT_SAMPLES - 15'h0001 |-> $stable(s_q.hi))
		else $error("shorthand tone changed mid-interval");

	// one word offered per interval start
	a_push_once:
	assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.pend && buf_in.ready |=> !s_q.pend || $past(ld) || $past(s_q.ap))
		else $error("tone word offered twice");
endmodule : wsmtx_top
`default_nettype wire

// ==== test/wsmtx_synth_model.sv ====
// Behavioural tone synthesizer that logs every tone word it takes
`timescale 1ns/10ps
`default_nettype none
module wsmtx_synth_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Tone words
	input wire logic [8:0] code,
	input wire logic valid,
	output logic ready,
	// Bench control
	input wire logic stall,
	input wire logic clr
);
	logic [8:0] words[$];
	int stamps[$];
	int n_valid;
	int cyc;
	logic [8:0] tone_q;
	logic [31:0] phase_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
			cyc <= 0;
			n_valid <= 0;
			tone_q <= 9'h000;
			phase_q <= 32'h00000000;
			words.delete();
			stamps.delete();
		end else begin
			ready <= !stall;
			cyc <= cyc + 1;
			// phase runs on across tone changes
			phase_q <= phase_q + 32'(tone_q);
			if (clr) begin
				words.delete();
				stamps.delete();
				n_valid <= 0;
			end else if (valid) begin
				n_valid <= n_valid + 1;
				// word taken on valid and ready
				if (ready) begin
					tone_q <= code;
					words.push_back(code);
					stamps.push_back(cyc);
				end
			end
		end
	end
endmodule : wsmtx_synth_model
`default_nettype wire

// ==== test/tb_weak_signal_mfsk_tx_encoder.sv ====
// Self-checking bench of the tone encoder over its AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_weak_signal_mfsk_tx_encoder;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h00000000;
	logic minute_tick = 1'b0;
	logic stall = 1'b0;
	logic clr = 1'b0;
	logic hready, hreadyout, hresp, tone_valid, tone_ready, tx_active;
	logic [31:0] hrdata;
	logic [8:0] tone_code;
	int mismatches = 0;
	int n_tests = 0;
	assign hready = hreadyout;
	always #4 hclk = ~hclk;
	wsmtx_top #(.SAMPLE_HZ(62500000), .LEAD_SAMPLES(15'h0004),
		.NORM_SAMPLES(15'h0004), .SHORT_SAMPLES(15'h0008)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .minute_tick(minute_tick), .tone_code(tone_code),
		.tone_valid(tone_valid), .tone_ready(tone_ready),
		.tx_active(tx_active));
	wsmtx_synth_model synth_u (.clk(hclk), .rst_n(hresetn),
		.code(tone_code), .valid(tone_valid), .ready(tone_ready),
		.stall(stall), .clr(clr));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= 32'(a);
		hwrite <= w;
		hsize <= wsmtx_pkg::HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer
	task automatic pulse(input logic t);
		@(posedge hclk);
		if (t) minute_tick <= 1'b1;
		else clr <= 1'b1;
		@(posedge hclk);
		minute_tick <= 1'b0;
		clr <= 1'b0;
	endtask : pulse
	function automatic logic [5:0] gm(input logic [5:0] a, input logic [5:0] b);
		logic [5:0] p;
		p = 6'h00;
		for (int i = 0; i < 6; i++) begin
			if (b[i]) p = p ^ a;
			a = a[5] ? ({a[4:0], 1'b0} ^ wsmtx_pkg::GF_REDUCE) : {a[4:0], 1'b0};
		end
		return p;
	endfunction : gm
	task automatic reg_test();
		logic [31:0] r;
		xfer(1'b0, wsmtx_pkg::OFS_CTRL, 32'h0, r);
		`CHK(r, 32'h00000000)
		xfer(1'b1, wsmtx_pkg::OFS_CTRL, 32'h000000FA, r);
		xfer(1'b0, wsmtx_pkg::OFS_CTRL, 32'h0, r);
		`CHK(r, 32'h000000D2)
		`CHK(hresp, 1'b0)
		xfer(1'b1, wsmtx_pkg::OFS_CTRL, 32'h0, r);
		xfer(1'b1, wsmtx_pkg::OFS_STATUS, 32'hFFFFFFFF, r);
		xfer(1'b0, wsmtx_pkg::OFS_STATUS, 32'h0, r);
		`CHK(r, 32'h00000000)
		xfer(1'b0, 8'h20, 32'h0, r);
		`CHK(r, 32'h00000000)
	endtask : reg_test
	task automatic run_short(input logic [1:0] ns, input logic [1:0] sub);
		logic [31:0] r;
		pulse(1'b0);
		// Shorthand started mid-minute, no tick needed
		xfer(1'b1, wsmtx_pkg::OFS_CTRL, 32'h4 | 32'(ns) << 3 | 32'(sub) << 5, r);
		repeat (60) @(posedge hclk);
		xfer(1'b1, wsmtx_pkg::OFS_CTRL, 32'h00000100, r);
		repeat (5) @(posedge hclk);
		`CHK(tx_active, 1'b0)
		`CHK(synth_u.words[0], 9'h000)
		`CHK(synth_u.words[1], 9'((int'(ns) + 2) * 10 << sub))
		`CHK(synth_u.words[2], 9'h000)
		`CHK(synth_u.stamps[2] - synth_u.stamps[1], 16)
	endtask : run_short
	task automatic run_normal(input logic rep, input logic [1:0] sub,
		input logic st);
		logic [5:0] s[12];
		logic [5:0] par[51];
		logic [5:0] cw[63];
		logic [8:0] e[126];
		logic [5:0] fb;
		logic [31:0] r;
		int k;
		for (int i = 0; i < 12; i++) s[i] = 6'(i * 7 + 3);
		for (int i = 0; i < 51; i++) par[i] = 6'h00;
		for (int i = 0; i < 12; i++) begin
			fb = s[i] ^ par[50];
			for (int j = 50; j > 0; j--)
				par[j] = par[j-1] ^ gm(fb, wsmtx_pkg::GEN[j]);
			par[0] = gm(fb, wsmtx_pkg::GEN[0]);
			cw[i] = s[i];
		end
		for (int i = 0; i < 51; i++) cw[12 + i] = par[50 - i];
		k = 0;
		for (int iv = 0; iv < 126; iv++) begin
			if (wsmtx_pkg::SYNC_DEFAULT[iv] ^ rep) begin
				e[iv] = 9'h000;
			end else begin
				fb = cw[(k % 7) * 9 + k / 7];
				e[iv] = 9'((int'(fb ^ (fb >> 1)) + 2) << sub);
				k++;
			end
		end
		pulse(1'b0);
		for (int i = 0; i < 3; i++)
			xfer(1'b1, 8'(4 + 4 * i),
				{8'h00, s[4*i+3], s[4*i+2], s[4*i+1], s[4*i]}, r);
		xfer(1'b1, wsmtx_pkg::OFS_CTRL, 32'h1 | 32'(rep) << 1 | 32'(sub) << 5, r);
		repeat (30) @(posedge hclk);
		pulse(1'b1);
		repeat (20) @(posedge hclk);
		xfer(1'b0, wsmtx_pkg::OFS_STATUS, 32'h0, r);
		`CHK(r[10:8], 3'h2)
		`CHK(synth_u.words.size(), 0)
		pulse(1'b1);
		repeat (3) @(posedge hclk);
		`CHK(tx_active, 1'b1)
		stall <= st;
		repeat (60) @(posedge hclk);
		stall <= 1'b0;
		for (int i = 0; i < 4000 && tx_active !== 1'b0; i++) @(posedge hclk);
		`CHK(synth_u.words.size(), 126)
		for (int i = 0; i < 126; i++)
			`CHK(synth_u.words[i], e[i])
		if (!st) begin
			`CHK(synth_u.stamps[125] - synth_u.stamps[0], 1000)
			`CHK(synth_u.n_valid, 126)
		end
	endtask : run_normal
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		reg_test();
		for (int i = 0; i < 3; i++) run_short(2'(i), 2'(i));
		run_normal(1'b0, 2'h0, 1'b1);
		run_normal(1'b1, 2'h2, 1'b0);
		finish_test();
	end
endmodule : tb_weak_signal_mfsk_tx_encoder
`default_nettype wire
